// file: design/bpc_calc.sv
`timescale 1ns/1ps
module bpc_calc (
  bpc_calc_if.calc c
);
  logic [16:0] seq_addr;
  logic [16:0] rel12_addr;
  logic [16:0] rel8_addr;
  logic [16:0] acc_addr;

  // ---------------------------------------------------------------
  // candidate targets, all 17 bits wide so carries fall off
  // ---------------------------------------------------------------
  always_comb
  begin
    seq_addr   = c.pc + {14'h0, c.byte_count};
    rel12_addr = c.pc + bpc_pkg::REL12_BIAS + {{5{c.off12[11]}}, c.off12};
    rel8_addr  = seq_addr + {{9{c.off8[7]}}, c.off8};
    acc_addr   = c.pc + bpc_pkg::ACC_BIAS + {9'h0, c.acc};
  end

  // ---------------------------------------------------------------
  // pick the target by instruction kind
  // ---------------------------------------------------------------
  always_comb
  begin
    c.ret_addr = seq_addr;
    unique case (c.kind)
      bpc_pkg::OP_ABS_JUMP,
      bpc_pkg::OP_ABS_CALL: c.target = c.abs_target;
      bpc_pkg::OP_REL_JUMP,
      bpc_pkg::OP_REL_CALL: c.target = rel12_addr;
      bpc_pkg::OP_COND:     c.target = c.taken ? rel8_addr : seq_addr;
      bpc_pkg::OP_ACC_CALL: c.target = acc_addr;
      bpc_pkg::OP_SEQ,
      bpc_pkg::OP_RETURN:   c.target = seq_addr;
    endcase
  end
endmodule

// file: design/bpc_calc_if.sv
`timescale 1ns/1ps
// carries the counter and operands to the target adder and its results back
interface bpc_calc_if;
  logic [16:0]         pc;
  bpc_pkg::bpc_op_type kind;
  logic                taken;
  logic [2:0]          byte_count;
  logic [16:0]         abs_target;
  logic [11:0]         off12;
  logic [7:0]          off8;
  logic [7:0]          acc;
  logic [16:0]         target;
  logic [16:0]         ret_addr;

  modport core (
    output pc, kind, taken, byte_count, abs_target, off12, off8, acc,
    input  target, ret_addr
  );
  modport calc (
    input  pc, kind, taken, byte_count, abs_target, off12, off8, acc,
    output target, ret_addr
  );
endinterface

// file: design/bpc_core.sv
`timescale 1ns/1ps
module bpc_core (
  input  wire logic              CORE_CLK_I,
  input  wire logic              RSTN_I,
  input  wire logic              START_OPT_I,
  input  wire logic              STEP_I,
  input  wire bpc_pkg::bpc_op_type OP_KIND_I,
  input  wire logic              COND_TAKEN_I,
  input  wire logic [2:0]        BYTE_COUNT_I,
  input  wire logic [16:0]       ABS_TARGET_I,
  input  wire logic [11:0]       OFFSET12_I,
  input  wire logic [7:0]        OFFSET8_I,
  input  wire logic [7:0]        ACC_I,
  input  wire logic [15:0]       SP_I,
  input  wire logic [8:0]        STACK_TOP_I,
  input  wire logic [8:0]        STACK_BELOW_I,
  input  wire logic              IRQ_TAKE_I,
  input  wire logic [9:0]        IRQ_REQ_I,
  input  wire logic [19:0]       IRQ_LEVEL_I,
  input  wire logic              LOOKUP_REQ_I,
  input  wire logic [16:0]       LOOKUP_PTR_I,
  input  wire logic              LOOKUP_BANK_I,
  output logic                   READY_O,
  output logic [16:0]            PC_O,
  output logic                   BANK_O,
  output logic [17:0]            FETCH_ADDR_O,
  output logic                   RESERVED_FETCH_O,
  output logic                   IRQ_ACK_O,
  output logic [3:0]             IRQ_INDEX_O,
  output logic                   PUSH_O,
  output logic [15:0]            PUSH_ADDR_LO_O,
  output logic [8:0]             PUSH_DATA_LO_O,
  output logic [15:0]            PUSH_ADDR_HI_O,
  output logic [8:0]             PUSH_DATA_HI_O,
  output logic                   LOOKUP_VALID_O,
  output logic [17:0]            LOOKUP_ADDR_O
);

  // ---------------------------------------------------------------
  // option strap synchroniser
  // ---------------------------------------------------------------
  logic opt_meta;
  logic opt_sync;
  logic next_opt_meta;
  logic next_opt_sync;

  // first flop feeds only the second
  always_comb
  begin
    next_opt_meta = START_OPT_I;
    next_opt_sync = opt_meta;
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      opt_meta <= 1'b0;
      opt_sync <= 1'b0;
    end
    else
    begin
      opt_meta <= next_opt_meta;
      opt_sync <= next_opt_sync;
    end
  end

  // ---------------------------------------------------------------
  // helpers: target adder and interrupt priority
  // ---------------------------------------------------------------
  bpc_calc_if calc_bus ();

  logic        irq_valid;
  logic [3:0]  irq_index;
  logic [16:0] irq_vector;

  bpc_calc u_calc (
    .c (calc_bus.calc)
  );

  bpc_prio u_prio (
    .req_i    (IRQ_REQ_I),
    .level_i  (IRQ_LEVEL_I),
    .valid_o  (irq_valid),
    .index_o  (irq_index),
    .vector_o (irq_vector)
  );

  // ---------------------------------------------------------------
  // program counter state
  // ---------------------------------------------------------------
  bpc_pkg::bpc_state_type state;
  bpc_pkg::bpc_state_type next_state;
  logic [1:0]  wait_cnt;
  logic [1:0]  next_wait_cnt;
  logic [16:0] pc;
  logic [16:0] next_pc;
  logic        bank;
  logic        next_bank;
  logic        reserved;
  logic        next_reserved;
  logic        irq_ack;
  logic        next_irq_ack;
  logic [3:0]  irq_idx_q;
  logic [3:0]  next_irq_idx_q;
  logic        push;
  logic        next_push;
  logic [15:0] push_addr_lo;
  logic [15:0] next_push_addr_lo;
  logic [15:0] push_addr_hi;
  logic [15:0] next_push_addr_hi;
  logic [8:0]  push_lo;
  logic [8:0]  next_push_lo;
  logic [8:0]  push_hi;
  logic [8:0]  next_push_hi;
  logic [16:0] save_addr;

  // feed the adder with the current counter and operands
  always_comb
  begin
    calc_bus.pc         = pc;
    calc_bus.kind       = OP_KIND_I;
    calc_bus.taken      = COND_TAKEN_I;
    calc_bus.byte_count = BYTE_COUNT_I;
    calc_bus.abs_target = ABS_TARGET_I;
    calc_bus.off12      = OFFSET12_I;
    calc_bus.off8       = OFFSET8_I;
    calc_bus.acc        = ACC_I;
  end

  // next counter, bank, stack save and interrupt acknowledge
  always_comb
  begin
    next_state        = state;
    next_wait_cnt     = wait_cnt;
    next_pc           = pc;
    next_bank         = bank;
    next_irq_ack      = 1'b0;
    next_irq_idx_q    = irq_idx_q;
    next_push         = 1'b0;
    next_push_addr_lo = push_addr_lo;
    next_push_addr_hi = push_addr_hi;
    next_push_lo      = push_lo;
    next_push_hi      = push_hi;
    save_addr         = calc_bus.ret_addr;
    unique case (state)
      bpc_pkg::ST_SYNC:
      begin
        next_wait_cnt = wait_cnt + 2'h1;
        if (wait_cnt == bpc_pkg::SYNC_WAIT)
        begin
          next_state = bpc_pkg::ST_LOAD;
        end
      end
      bpc_pkg::ST_LOAD:
      begin
        // strap now settled: pick the start address
        next_pc    = opt_sync ? bpc_pkg::START_ALT : bpc_pkg::START_PLAIN;
        next_bank  = bpc_pkg::BANK_RESET;
        next_state = bpc_pkg::ST_RUN;
      end
      bpc_pkg::ST_RUN:
      begin
        if (IRQ_TAKE_I && irq_valid)
        begin
          // interrupt wins over the completing instruction
          save_addr      = pc;
          next_pc        = irq_vector;
          next_bank      = 1'b0;
          next_irq_ack   = 1'b1;
          next_irq_idx_q = irq_index;
          next_push      = 1'b1;
        end
        else if (STEP_I)
        begin
          next_pc = calc_bus.target;
          // bank stays except on a return
          if (OP_KIND_I == bpc_pkg::OP_RETURN)
          begin
            next_pc   = {STACK_TOP_I, STACK_BELOW_I[7:0]};
            next_bank = STACK_BELOW_I[8];
          end
          if ((OP_KIND_I == bpc_pkg::OP_ABS_CALL) ||
              (OP_KIND_I == bpc_pkg::OP_REL_CALL) ||
              (OP_KIND_I == bpc_pkg::OP_ACC_CALL))
          begin
            next_push = 1'b1;
          end
        end
      end
    endcase
    if (next_push)
    begin
      // low word holds the bank and low byte, high word the top 9 bits
      next_push_addr_lo = SP_I + bpc_pkg::SP_LO_OFS;
      next_push_addr_hi = SP_I + bpc_pkg::SP_HI_OFS;
      next_push_lo      = {bank, save_addr[7:0]};
      next_push_hi      = save_addr[16:8];
    end
    // flag a fetch that would fall in the bank 0 option area
    next_reserved = !next_bank && (next_pc[16:8] == bpc_pkg::OPT_AREA_HI);
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state        <= bpc_pkg::ST_SYNC;
      wait_cnt     <= 2'h0;
      pc           <= bpc_pkg::START_PLAIN;
      bank         <= bpc_pkg::BANK_RESET;
      reserved     <= 1'b0;
      irq_ack      <= 1'b0;
      irq_idx_q    <= 4'h0;
      push         <= 1'b0;
      push_addr_lo <= 16'h0000;
      push_addr_hi <= 16'h0000;
      push_lo      <= 9'h000;
      push_hi      <= 9'h000;
    end
    else
    begin
      state        <= next_state;
      wait_cnt     <= next_wait_cnt;
      pc           <= next_pc;
      bank         <= next_bank;
      reserved     <= next_reserved;
      irq_ack      <= next_irq_ack;
      irq_idx_q    <= next_irq_idx_q;
      push         <= next_push;
      push_addr_lo <= next_push_addr_lo;
      push_addr_hi <= next_push_addr_hi;
      push_lo      <= next_push_lo;
      push_hi      <= next_push_hi;
    end
  end

  // ---------------------------------------------------------------
  // table lookup address
  // ---------------------------------------------------------------
  logic        lk_valid;
  logic        next_lk_valid;
  logic [17:0] lk_addr;
  logic [17:0] next_lk_addr;

  // any byte of the chosen bank, independent of the counter
  always_comb
  begin
    next_lk_valid = LOOKUP_REQ_I;
    next_lk_addr  = lk_addr;
    if (LOOKUP_REQ_I)
    begin
      next_lk_addr = {LOOKUP_BANK_I, LOOKUP_PTR_I};
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      lk_valid <= 1'b0;
      lk_addr  <= 18'h00000;
    end
    else
    begin
      lk_valid <= next_lk_valid;
      lk_addr  <= next_lk_addr;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign READY_O          = (state == bpc_pkg::ST_RUN);
  assign PC_O             = pc;
  assign BANK_O           = bank;
  assign FETCH_ADDR_O     = {bank, pc};
  assign RESERVED_FETCH_O = reserved;
  assign IRQ_ACK_O        = irq_ack;
  assign IRQ_INDEX_O      = irq_idx_q;
  assign PUSH_O           = push;
  assign PUSH_ADDR_LO_O   = push_addr_lo;
  assign PUSH_DATA_LO_O   = push_lo;
  assign PUSH_ADDR_HI_O   = push_addr_hi;
  assign PUSH_DATA_HI_O   = push_hi;
  assign LOOKUP_VALID_O   = lk_valid;
  assign LOOKUP_ADDR_O    = lk_addr;

endmodule

// file: design/bpc_pkg.sv
package bpc_pkg;

  // ---------------------------------------------------------------
  // widths and addresses
  // ---------------------------------------------------------------
  localparam int          PC_W        = 17;
  localparam int          FETCH_W     = 18;
  localparam int          SP_W        = 16;
  localparam int          NUM_VEC     = 10;
  localparam int          VEC_IDX_W   = 4;
  localparam logic [16:0] START_PLAIN = 17'h00000;
  localparam logic [16:0] START_ALT   = 17'h0fe00;
  localparam logic        BANK_RESET  = 1'h0;
  localparam logic [16:0] VEC_BASE    = 17'h00003;
  localparam logic [16:0] VEC_STEP    = 17'h00008;
  localparam logic [8:0]  OPT_AREA_HI = 9'h0ff;
  localparam logic [16:0] REL12_BIAS  = 17'h00002;
  localparam logic [16:0] ACC_BIAS    = 17'h00001;
  localparam logic [15:0] SP_LO_OFS   = 16'h0001;
  localparam logic [15:0] SP_HI_OFS   = 16'h0002;
  localparam logic [1:0]  SYNC_WAIT   = 2'h2;

  // ---------------------------------------------------------------
  // interrupt levels
  // ---------------------------------------------------------------
  localparam logic [1:0]  LVL_L = 2'h0;
  localparam logic [1:0]  LVL_H = 2'h1;
  localparam logic [1:0]  LVL_X = 2'h2;

  // ---------------------------------------------------------------
  // kinds of completing instruction
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_SEQ      = 3'h0,
    OP_ABS_JUMP = 3'h1,
    OP_ABS_CALL = 3'h2,
    OP_REL_JUMP = 3'h3,
    OP_REL_CALL = 3'h4,
    OP_COND     = 3'h5,
    OP_ACC_CALL = 3'h6,
    OP_RETURN   = 3'h7
  } bpc_op_type;

  // ---------------------------------------------------------------
  // start-up sequence states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SYNC = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN  = 3'b100
  } bpc_state_type;

endpackage

// file: design/bpc_prio.sv
`timescale 1ns/1ps
module bpc_prio (
  input  wire logic [9:0]  req_i,
  input  wire logic [19:0] level_i,
  output logic             valid_o,
  output logic [3:0]       index_o,
  output logic [16:0]      vector_o
);
  logic [1:0] best_lvl;

  // ---------------------------------------------------------------
  // scan upward; a later source wins only on a strictly higher level
  // ---------------------------------------------------------------
  always_comb
  begin
    valid_o  = 1'b0;
    index_o  = 4'h0;
    best_lvl = bpc_pkg::LVL_L;
    for (int i = 0; i < bpc_pkg::NUM_VEC; i++)
    begin
      if (req_i[i] && (!valid_o || (level_i[2*i +: 2] > best_lvl)))
      begin
        valid_o  = 1'b1;
        index_o  = 4'(i);
        best_lvl = level_i[2*i +: 2];
      end
    end
    vector_o = bpc_pkg::VEC_BASE + {index_o, 3'h0};
  end
endmodule

// file: dv/bpc_core_monitor.sv
`timescale 1ns/1ps
// watches the counter ports and checks update relations
module bpc_core_monitor (
  input wire logic                CORE_CLK_I,
  input wire logic                RSTN_I,
  input wire logic                START_OPT_I,
  input wire logic                STEP_I,
  input wire bpc_pkg::bpc_op_type OP_KIND_I,
  input wire logic [2:0]          BYTE_COUNT_I,
  input wire logic [15:0]         SP_I,
  input wire logic [8:0]          STACK_TOP_I,
  input wire logic [8:0]          STACK_BELOW_I,
  input wire logic                IRQ_TAKE_I,
  input wire logic [9:0]          IRQ_REQ_I,
  input wire logic                READY_O,
  input wire logic [16:0]         PC_O,
  input wire logic                BANK_O,
  input wire logic [17:0]         FETCH_ADDR_O,
  input wire logic                RESERVED_FETCH_O,
  input wire logic                IRQ_ACK_O,
  input wire logic [3:0]          IRQ_INDEX_O,
  input wire logic                PUSH_O,
  input wire logic [15:0]         PUSH_ADDR_LO_O,
  input wire logic [15:0]         PUSH_ADDR_HI_O
);
  logic irq_ok;
  logic ret_ok;
  logic seq_ok;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // accepted interrupt, accepted return step and accepted plain step
  assign irq_ok = READY_O && IRQ_TAKE_I && (|IRQ_REQ_I);
  assign ret_ok = READY_O && STEP_I && !irq_ok && OP_KIND_I == bpc_pkg::OP_RETURN;
  assign seq_ok = READY_O && STEP_I && !irq_ok && OP_KIND_I == bpc_pkg::OP_SEQ;

  property p_start;
    $rose(READY_O) |-> FETCH_ADDR_O == (START_OPT_I ? 18'h0fe00 : 18'h00000);
  endproperty
  a_start: assert property (p_start) else $error("start address wrong");
  property p_irq_vec;
    IRQ_ACK_O |-> PC_O == 17'h00003 + {IRQ_INDEX_O, 3'h0} && !BANK_O;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("vector wrong");
  property p_irq_cause;
    irq_ok |=> IRQ_ACK_O && PUSH_O;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt not taken");
  property p_push_addr;
    $rose(PUSH_O) |-> PUSH_ADDR_LO_O == $past(SP_I) + 16'h0001
      && PUSH_ADDR_HI_O == $past(SP_I) + 16'h0002;
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push address wrong");
  property p_ret;
    ret_ok |=> {FETCH_ADDR_O[17], FETCH_ADDR_O[7:0]} == $past(STACK_BELOW_I)
      && FETCH_ADDR_O[16:8] == $past(STACK_TOP_I);
  endproperty
  a_ret: assert property (p_ret) else $error("return address wrong");
  property p_bank;
    $past(READY_O) && BANK_O != $past(BANK_O) |-> IRQ_ACK_O || $past(ret_ok);
  endproperty
  a_bank: assert property (p_bank) else $error("bank changed");
  property p_resv;
    (!BANK_O && PC_O[16:8] == 9'h0ff) [*2] |-> RESERVED_FETCH_O;
  endproperty
  a_resv: assert property (p_resv) else $error("option area not flagged");
  // plain step advances by its byte count, wraps in the bank, keeps the bank
  property p_fetch;
    seq_ok |=> PC_O == $past(PC_O) + 17'($past(BYTE_COUNT_I))
      && BANK_O == $past(BANK_O) && FETCH_ADDR_O == {BANK_O, PC_O};
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrong");

  c_irq: cover property (IRQ_ACK_O);
  c_bank: cover property ($rose(BANK_O));
  c_resv: cover property (RESERVED_FETCH_O);
endmodule

bind bpc_core bpc_core_monitor mon_u (.CORE_CLK_I, .RSTN_I, .START_OPT_I, .STEP_I,
  .OP_KIND_I, .BYTE_COUNT_I, .SP_I, .STACK_TOP_I, .STACK_BELOW_I, .IRQ_TAKE_I, .IRQ_REQ_I,
  .READY_O,
  .PC_O, .BANK_O, .FETCH_ADDR_O, .RESERVED_FETCH_O, .IRQ_ACK_O, .IRQ_INDEX_O, .PUSH_O,
  .PUSH_ADDR_LO_O, .PUSH_ADDR_HI_O);

// file: dv/bpc_core_tb_top.sv
`timescale 1ns/1ps
// drives the counter, models its stack and judges each update
module bpc_core_tb_top;
  logic CORE_CLK_I, RSTN_I, START_OPT_I, STEP_I, COND_TAKEN_I, IRQ_TAKE_I, LOOKUP_REQ_I;
  logic LOOKUP_BANK_I, READY_O, BANK_O, RESERVED_FETCH_O, IRQ_ACK_O, PUSH_O, LOOKUP_VALID_O;
  logic pop, bank_set, mbank;
  bpc_pkg::bpc_op_type OP_KIND_I;
  logic [2:0]  BYTE_COUNT_I;
  logic [16:0] ABS_TARGET_I, LOOKUP_PTR_I, PC_O, mpc;
  logic [11:0] OFFSET12_I;
  logic [7:0]  OFFSET8_I, ACC_I;
  logic [15:0] SP_I, PUSH_ADDR_LO_O, PUSH_ADDR_HI_O;
  logic [8:0]  STACK_TOP_I, STACK_BELOW_I, PUSH_DATA_LO_O, PUSH_DATA_HI_O;
  logic [9:0]  IRQ_REQ_I;
  logic [19:0] IRQ_LEVEL_I;
  logic [17:0] FETCH_ADDR_O, LOOKUP_ADDR_O;
  logic [3:0]  IRQ_INDEX_O;
  int          fails;
  int          n_checks;

  bpc_core dut_u (.CORE_CLK_I, .RSTN_I, .START_OPT_I, .STEP_I, .OP_KIND_I, .COND_TAKEN_I,
    .BYTE_COUNT_I, .ABS_TARGET_I, .OFFSET12_I, .OFFSET8_I, .ACC_I, .SP_I, .STACK_TOP_I,
    .STACK_BELOW_I, .IRQ_TAKE_I, .IRQ_REQ_I, .IRQ_LEVEL_I, .LOOKUP_REQ_I, .LOOKUP_PTR_I,
    .LOOKUP_BANK_I, .READY_O, .PC_O, .BANK_O, .FETCH_ADDR_O, .RESERVED_FETCH_O, .IRQ_ACK_O,
    .IRQ_INDEX_O, .PUSH_O, .PUSH_ADDR_LO_O, .PUSH_DATA_LO_O, .PUSH_ADDR_HI_O,
    .PUSH_DATA_HI_O, .LOOKUP_VALID_O, .LOOKUP_ADDR_O);

  assign pop = STEP_I && READY_O && OP_KIND_I == bpc_pkg::OP_RETURN && !IRQ_TAKE_I;
  bpc_stack_model stack_u (.clk_i(CORE_CLK_I), .rstn_i(RSTN_I), .push_i(PUSH_O),
    .pop_i(pop), .bank_set_i(bank_set), .push_addr_lo_i(PUSH_ADDR_LO_O),
    .push_data_lo_i(PUSH_DATA_LO_O), .push_addr_hi_i(PUSH_ADDR_HI_O),
    .push_data_hi_i(PUSH_DATA_HI_O), .sp_o(SP_I), .top_o(STACK_TOP_I), .below_o(STACK_BELOW_I));

  // clock
  initial
  begin
    CORE_CLK_I = 1'b0;
    forever #5 CORE_CLK_I = ~CORE_CLK_I;
  end

  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // reset with a strap value, then wait for the start address
  task automatic do_reset(input logic opt);
    int n;
    @(posedge CORE_CLK_I);
    RSTN_I <= 1'b0;
    START_OPT_I <= opt;
    repeat (8) @(posedge CORE_CLK_I);
    RSTN_I <= 1'b1;
    n = 0;
    while (READY_O !== 1'b1 && n < 20)
    begin
      @(posedge CORE_CLK_I);
      #1;
      n++;
    end
    {mbank, mpc} = {1'b0, opt ? 17'h0fe00 : 17'h00000};
    chk("start", FETCH_ADDR_O, {mbank, mpc});
  endtask

  // one completing instruction, fetch address judged after its edge
  task automatic stp(input bpc_pkg::bpc_op_type k, input logic tk, input logic [2:0] nb,
    input logic [16:0] a, input logic [11:0] o12, input logic [7:0] o8, input logic [7:0] ac,
    input logic [17:0] exp);
    @(posedge CORE_CLK_I);
    STEP_I <= 1'b1;
    OP_KIND_I <= k;
    COND_TAKEN_I <= tk;
    BYTE_COUNT_I <= nb;
    ABS_TARGET_I <= a;
    OFFSET12_I <= o12;
    OFFSET8_I <= o8;
    ACC_I <= ac;
    @(posedge CORE_CLK_I);
    STEP_I <= 1'b0;
    #1;
    {mbank, mpc} = exp;
    chk("fetch", FETCH_ADDR_O, exp);
    chk("bank pc", {BANK_O, PC_O}, exp);
  endtask

  // interrupt with a competing step; checks vector, index and pushed words
  task automatic irq(input logic [9:0] req, input logic [19:0] lvl, input logic [3:0] idx);
    logic [17:0] ret;
    ret = {mbank, mpc};
    @(posedge CORE_CLK_I);
    IRQ_TAKE_I <= 1'b1;
    IRQ_REQ_I <= req;
    IRQ_LEVEL_I <= lvl;
    STEP_I <= 1'b1;
    OP_KIND_I <= bpc_pkg::OP_SEQ;
    @(posedge CORE_CLK_I);
    IRQ_TAKE_I <= 1'b0;
    STEP_I <= 1'b0;
    #1;
    {mbank, mpc} = {1'b0, 17'h00003 + {idx, 3'h0}};
    chk("vector", FETCH_ADDR_O, {mbank, mpc});
    chk("index", {14'h0, IRQ_INDEX_O}, {14'h0, idx});
    chk("ack push", {16'h0, IRQ_ACK_O, PUSH_O}, 18'h00003);
    chk("push lo", {9'h0, PUSH_DATA_LO_O}, {9'h0, ret[17], ret[7:0]});
    chk("push hi", {9'h0, PUSH_DATA_HI_O}, {9'h0, ret[16:8]});
  endtask

  // table lookup, address one cycle after the request
  task automatic look(input logic b, input logic [16:0] p);
    @(posedge CORE_CLK_I);
    LOOKUP_REQ_I <= 1'b1;
    LOOKUP_BANK_I <= b;
    LOOKUP_PTR_I <= p;
    @(posedge CORE_CLK_I);
    LOOKUP_REQ_I <= 1'b0;
    #1;
    chk("lookup", {LOOKUP_VALID_O, LOOKUP_ADDR_O[17:1]}, {1'b1, b, p[16:1]});
    chk("lookup lsb", {17'h0, LOOKUP_ADDR_O[0]}, {17'h0, p[0]});
  endtask

  // option area flag after a jump into or out of it
  task automatic resv(input logic [16:0] a, input logic exp);
    stp(bpc_pkg::OP_ABS_JUMP, 0, 3, a, 0, 0, 0, {mbank, a});
    repeat (2) @(posedge CORE_CLK_I);
    #1;
    chk("reserved", {17'h0, RESERVED_FETCH_O}, {17'h0, exp});
  endtask

  initial
  begin
    {RSTN_I, START_OPT_I, STEP_I, COND_TAKEN_I, IRQ_TAKE_I, LOOKUP_REQ_I} = 6'h00;
    {LOOKUP_BANK_I, bank_set, BYTE_COUNT_I, ACC_I, OFFSET8_I, OFFSET12_I} = 33'h0;
    {ABS_TARGET_I, LOOKUP_PTR_I, IRQ_REQ_I, IRQ_LEVEL_I} = 64'h0;
    OP_KIND_I = bpc_pkg::OP_SEQ;
    fails = 0;
    n_checks = 0;
    do_reset(1'b1);
    stp(bpc_pkg::OP_REL_JUMP, 0, 2, 0, 12'h800, 0, 0, {1'b0, mpc + 17'h2 - 17'h800});
    stp(bpc_pkg::OP_REL_CALL, 0, 2, 0, 12'h7ff, 0, 0, {1'b0, mpc + 17'h2 + 17'h7ff});
    stp(bpc_pkg::OP_RETURN, 0, 1, 0, 0, 0, 0, {1'b0, 17'h0f604});
    stp(bpc_pkg::OP_ABS_JUMP, 0, 3, 17'h1fffe, 0, 0, 0, {1'b0, 17'h1fffe});
    stp(bpc_pkg::OP_SEQ, 0, 3, 0, 0, 0, 0, {1'b0, 17'h00001});
    stp(bpc_pkg::OP_COND, 1, 3, 0, 0, 8'h80, 0, {1'b0, 17'h1ff84});
    stp(bpc_pkg::OP_COND, 0, 2, 0, 0, 8'h7f, 0, {1'b0, 17'h1ff86});
    stp(bpc_pkg::OP_COND, 1, 4, 0, 0, 8'h7f, 0, {1'b0, 17'h00009});
    stp(bpc_pkg::OP_ACC_CALL, 0, 1, 0, 0, 0, 8'hff, {1'b0, 17'h00109});
    chk("push lo", {9'h0, PUSH_DATA_LO_O}, {9'h0, 9'h00a});
    stp(bpc_pkg::OP_ABS_CALL, 0, 3, 17'h12345, 0, 0, 0, {1'b0, 17'h12345});
    @(posedge CORE_CLK_I);
    bank_set <= 1'b1;
    stp(bpc_pkg::OP_RETURN, 0, 1, 0, 0, 0, 0, {1'b1, 17'h0010c});
    bank_set <= 1'b0;
    stp(bpc_pkg::OP_SEQ, 0, 1, 0, 0, 0, 0, {1'b1, 17'h0010d});
    stp(bpc_pkg::OP_ABS_JUMP, 0, 3, 17'h0ff00, 0, 0, 0, {1'b1, 17'h0ff00});
    irq(10'h0a2, 20'h08804, 4'h5);
    irq(10'h201, 20'h00000, 4'h0);
    irq(10'h300, 20'h40000, 4'h9);
    look(1'b1, 17'h1ffff);
    look(1'b0, 17'h0ff00);
    resv(17'h0ff10, 1'b1);
    resv(17'h10000, 1'b0);
    do_reset(1'b0);
    end_sim();
  end

  // hang guard: the sequence needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge CORE_CLK_I);
    fails++;
    end_sim();
  end
endmodule

// file: dv/bpc_stack_model.sv
`timescale 1ns/1ps
// stack memory at the far side: stores pushed word pairs, serves return words
module bpc_stack_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        push_i,
  input  wire logic        pop_i,
  input  wire logic        bank_set_i,
  input  wire logic [15:0] push_addr_lo_i,
  input  wire logic [8:0]  push_data_lo_i,
  input  wire logic [15:0] push_addr_hi_i,
  input  wire logic [8:0]  push_data_hi_i,
  output logic      [15:0] sp_o,
  output logic      [8:0]  top_o,
  output logic      [8:0]  below_o
);
  logic [8:0]  ram [0:255];
  logic [15:0] next_sp;
  logic [7:0]  below_idx;

  // pointer moves two words per push or return
  always_comb
  begin
    next_sp = sp_o;
    if (push_i)
      next_sp = sp_o + 16'h0002;
    else if (pop_i)
      next_sp = sp_o - 16'h0002;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sp_o <= 16'h0000;
    else
      sp_o <= next_sp;
  end

  // word pair lands at the addresses the counter reports
  always_ff @(posedge clk_i)
  begin
    if (push_i)
    begin
      ram[push_addr_lo_i[7:0]] <= push_data_lo_i;
      ram[push_addr_hi_i[7:0]] <= push_data_hi_i;
    end
  end

  // bank_set_i stands for software rewriting the stacked bank bit
  assign below_idx = sp_o[7:0] - 8'h01;
  assign top_o     = ram[sp_o[7:0]];
  assign below_o   = {ram[below_idx][8] | bank_set_i, ram[below_idx][7:0]};
endmodule
